// File: lrx_fifo.sv
// Purpose: small two-rail FIFO with registered read data
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes:   limit_in caps the usable length at or below DEPTH
`timescale 1ns/1ps
module lrx_fifo #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	// clock, reset, enable
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	input  wire logic             clear_in,
	input  wire logic [AW:0]      limit_in,
	// fill side
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// drain side
	input  wire logic             rd_ready_in,
	output logic                  rd_valid_out,
	output logic [WIDTH-1:0]      rd_data_out,
	output logic [AW:0]           level_out
);

	logic [WIDTH-1:0] mem [DEPTH];   // storage
	logic [AW-1:0]    wptr;          // write pointer
	logic [AW-1:0]    rptr;          // read pointer
	logic             push;
	logic             pop;

	// full is judged against the programmed length, not DEPTH
	assign wr_ready_out = (level_out < limit_in);
	assign push = wr_valid_in & wr_ready_out;
	assign pop  = rd_ready_in & (level_out != '0);

	// ------------------------------------------------------------
	// pointers and level
	// ------------------------------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (rst_in | (ce_in & clear_in))
		begin
			wptr      <= '0;
			rptr      <= '0;
			level_out <= '0;
		end
		else if (ce_in)
		begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			if (push & ~pop)
				level_out <= level_out + 1'b1;
			else if (pop & ~push)
				level_out <= level_out - 1'b1;
		end
	end

	// storage carries no reset
	always_ff @(posedge clock_in)
	begin
		if (ce_in & push)
			mem[wptr] <= wr_data_in;
	end

	// ------------------------------------------------------------
	// registered read port, valid one cycle after the pop
	// ------------------------------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= '0;
		end
		else if (ce_in)
		begin
			rd_valid_out <= pop & ~clear_in;
			if (pop)
				rd_data_out <= mem[rptr];
		end
	end

endmodule // lrx_fifo

// File: lrx_framer.sv
// Purpose: framer stand-in tallying received bits
// Assumes: samples mid-bit, opposite the update edge
// Notes:   counts wrap; the bench uses differences
`timescale 1ns/1ps
module lrx_framer (
	// clock, reset, edge choice
	input wire logic  clock_in,
	input wire logic  rst_in,
	input wire logic  fall_in,
	// stream in
	input wire logic  rx_clock_in,
	input wire logic  data_in,
	input wire logic  vio_in,
	// tallies
	output logic [7:0] ones_out,
	output logic [7:0] vios_out
);
	logic last; // clock level seen last cycle
	// one full-period pulse is seen exactly once
	always_ff @(posedge clock_in)
	begin
		last <= rx_clock_in;
		if (rst_in)
		begin
			ones_out <= 8'h00;
			vios_out <= 8'h00;
		end
		else if (last != rx_clock_in && rx_clock_in == fall_in)
		begin
			ones_out <= ones_out + 8'(data_in);
			vios_out <= vios_out + 8'(vio_in);
		end
	end
endmodule // lrx_framer

// File: lrx_pkg.sv
// Purpose: shared constants and types for the line receive block
// Assumes: one channel per instance, 100 MHz system clock
// Notes:   counts are in received bits unless named otherwise
package lrx_pkg;

	// ------------------------------------------------------------
	// loss-of-signal detector
	// ------------------------------------------------------------
	localparam int unsigned ZRUN_W   = 13;            // zero run width
	localparam int unsigned WIN_W    = 8;             // window counters
	localparam logic [12:0] LOS_E1_ZEROS     = 13'h0020; // 32 zeros
	localparam logic [12:0] LOS_E1_EXT_ZEROS = 13'h1000; // 4096 zeros
	localparam logic [12:0] LOS_T1_ZEROS     = 13'h00AF; // 175 zeros
	localparam logic [12:0] ZRUN_MAX         = 13'h1FFF; // saturation
	localparam logic [7:0]  CLR_E1_ONES = 8'h04;     // 4 ones needed
	localparam logic [7:0]  CLR_E1_WIN  = 8'h20;     // 32 bit window
	localparam logic [12:0] CLR_E1_RUN  = 13'h0010;  // max 16 zeros
	localparam logic [7:0]  CLR_T1_ONES = 8'h10;     // 16 ones needed
	localparam logic [7:0]  CLR_T1_WIN  = 8'h80;     // 128 bit window
	localparam logic [12:0] CLR_T1_RUN  = 13'h0064;  // max 100 zeros

	// ------------------------------------------------------------
	// decoder
	// ------------------------------------------------------------
	localparam int unsigned DEC_LEN   = 8;           // decode delay line
	localparam logic [2:0]  EXZ_RUN   = 3'h3;        // zeros before 4th
	localparam logic [7:0]  B8ZS_MASK = 8'h0D;       // V, B, V of 000VB0V
	localparam logic [7:0]  HDB3_MASK = 8'h04;       // B of B00V
	localparam int unsigned EQC_HI    = 4;           // mode bit positions
	localparam int unsigned EQC_LO    = 3;

	// ------------------------------------------------------------
	// jitter attenuator
	// ------------------------------------------------------------
	localparam int unsigned JA_WIDTH  = 2;           // {neg, pos} rails
	localparam int unsigned JA_DEPTH  = 64;          // largest length
	localparam int unsigned JA_AW     = 6;
	localparam logic [6:0]  JA_SHORT  = 7'h20;       // 32 bit length
	localparam logic [6:0]  JA_LONG   = 7'h40;       // 64 bit length
	localparam logic [6:0]  JA_MARGIN = 7'h02;       // two bit window

	typedef enum logic [1:0] {
		JA_OFF = 2'h0,
		JA_RX  = 2'h1,
		JA_TX  = 2'h2
	} lrx_ja_path_e;

	// gray along fill -> narrow -> wide
	typedef enum logic [1:0] {
		JS_FILL   = 2'h0,
		JS_NARROW = 2'h1,
		JS_WIDE   = 2'h3
	} lrx_ja_state_e;

	// ------------------------------------------------------------
	// pin synchroniser lanes
	// ------------------------------------------------------------
	localparam int unsigned NPINS    = 11;
	localparam int unsigned P_RCLK   = 0;
	localparam int unsigned P_RPOS   = 1;
	localparam int unsigned P_RNEG   = 2;
	localparam int unsigned P_ALOSS  = 3;
	localparam int unsigned P_AREST  = 4;
	localparam int unsigned P_MCLK   = 5;
	localparam int unsigned P_TCLK   = 6;
	localparam int unsigned P_TPOS   = 7;
	localparam int unsigned P_TNEG   = 8;
	localparam int unsigned P_EDGE   = 9;
	localparam int unsigned P_CODE   = 10;

endpackage

// File: lrx_rx_line.sv
// Purpose: receive loss detector, line decoder, jitter attenuator
// Assumes: link clocks are slow pins sampled by clock_in
// Notes:   decoder adds a fixed eight bit delay in single rail
//
// How it works
// - loss flag after 32/4096/175 zeros under analog loss
// - E1 clear: 4 ones/32 bits, run<=16
// - T1 clear: 16 ones/128 bits, run<=100
// - loss event sets status, drives interrupt low
// - status read clears status, interrupt returns high
// - attenuator first, then decoder, then outputs
// - decode single rail only; coding bit or pin
// - HDB3 in E1, B8ZS in T1
// - non-code violations pulse one recovered clock
// - E1 excessive zeros also flagged
// - AMI flags every bipolar violation
// - edge select picks output update edge
// - hardware mode takes edge select from pin
// - attenuator in receive, transmit, or off
// - attenuator length 32 or 64 bits
// - nominal latency half the length
// - near margin widen bandwidth to track input
// - narrow again once outside two bit margin
// - E1 bandwidth select forces 64 bit length
// - rail format chosen by select input
// - E1 when equalizer bits 4 and 3 set
// - coding select 1 means AMI
`timescale 1ns/1ps
module lrx_rx_line (
	// clock, reset, enable
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	// recovered line side pins
	input  wire logic       rclk_in,
	input  wire logic       rx_pos_in,
	input  wire logic       rx_neg_in,
	input  wire logic       analog_loss_in,
	input  wire logic       analog_restore_in,
	input  wire logic       mclk_in,
	// transmit stream pins for attenuator in transmit path
	input  wire logic       tx_clock_in,
	input  wire logic       tx_pos_in,
	input  wire logic       tx_neg_in,
	// hardware mode pins
	input  wire logic       hw_mode_in,
	input  wire logic       rx_clock_edge_pin_in,
	input  wire logic       tx_negative_coding_pin_in,
	// host mode control bits
	input  wire logic       coding_select_in,
	input  wire logic       rx_clock_edge_select_in,
	input  wire logic       rail_format_select_in,
	input  wire logic [4:0] equalizer_control_in,
	input  wire logic       extended_loss_select_in,
	input  wire logic [1:0] ja_path_in,
	input  wire logic       ja_depth_long_in,
	input  wire logic       attenuator_bandwidth_select_in,
	input  wire logic       loss_int_enable_in,
	input  wire logic       status_read_in,
	// receive outputs to framer
	output logic            rx_clock_out,
	output logic            rx_positive_data_out,
	output logic            rx_negative_violation_out,
	// alarm outputs
	output logic            receive_loss_flag_out,
	output logic            loss_status_out,
	output logic            int_n_out,
	// transmit outputs
	output logic            tx_clock_out,
	output logic            tx_pos_out,
	output logic            tx_neg_out,
	// attenuator status
	output logic            ja_wide_out,
	output logic            ja_overflow_out,
	output logic [6:0]      ja_level_out
);

	// ------------------------------------------------------------
	// pin synchronisers and edge finders
	// ------------------------------------------------------------
	logic [lrx_pkg::NPINS-1:0] pin_raw;   // slow pins other than hw_mode_in
	logic [lrx_pkg::NPINS-1:0] pin_s1;    // first stage, private
	logic [lrx_pkg::NPINS-1:0] pin_s2;    // usable samples
	logic [lrx_pkg::NPINS-1:0] pin_d;     // previous sample
	logic rclk_rise;
	logic mclk_rise;
	logic tclk_rise;

	assign pin_raw = {tx_negative_coding_pin_in, rx_clock_edge_pin_in,
		tx_neg_in, tx_pos_in, tx_clock_in, mclk_in, analog_restore_in,
		analog_loss_in, rx_neg_in, rx_pos_in, rclk_in};

	// two flops before any logic looks at a pin other than hw_mode_in
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_d  <= '0;
		end
		else if (ce_in)
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
		end
	end

	assign rclk_rise = pin_s2[lrx_pkg::P_RCLK] & ~pin_d[lrx_pkg::P_RCLK];
	assign mclk_rise = pin_s2[lrx_pkg::P_MCLK] & ~pin_d[lrx_pkg::P_MCLK];
	assign tclk_rise = pin_s2[lrx_pkg::P_TCLK] & ~pin_d[lrx_pkg::P_TCLK];

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	logic e1_mode;      // E1 rather than T1/J1
	logic ami;          // plain AMI coding
	logic edge_fall;    // update outputs on falling clock
	logic single_rail;  // decoder in use
	logic rx_mark;      // raw received pulse
	logic [1:0] rx_sym; // raw {neg, pos}

	assign e1_mode = equalizer_control_in[lrx_pkg::EQC_HI]
		& equalizer_control_in[lrx_pkg::EQC_LO];
	assign ami = hw_mode_in ? pin_s2[lrx_pkg::P_CODE]
		: coding_select_in;
	assign edge_fall = hw_mode_in ? pin_s2[lrx_pkg::P_EDGE]
		: rx_clock_edge_select_in;
	assign single_rail = rail_format_select_in;
	assign rx_sym  = {pin_s2[lrx_pkg::P_RNEG], pin_s2[lrx_pkg::P_RPOS]};
	assign rx_mark = |rx_sym;

	// ------------------------------------------------------------
	// loss of signal: zero run, assert and clear windows
	// ------------------------------------------------------------
	logic [12:0] zero_run;     // consecutive zeros seen
	logic [12:0] next_run;
	logic [12:0] los_thresh;   // declare count
	logic [12:0] run_limit;    // longest run allowed to clear
	logic [7:0]  win_len;      // clear window length
	logic [7:0]  ones_need;    // ones needed in the window
	logic [7:0]  win_cnt;      // bits into the window
	logic [7:0]  ones_cnt;     // ones in the window
	logic [7:0]  next_ones;
	logic        run_bad;      // a run broke the limit
	logic        next_bad;
	logic        win_end;
	logic        aloss;

	assign aloss = pin_s2[lrx_pkg::P_ALOSS];
	assign los_thresh = ~e1_mode ? lrx_pkg::LOS_T1_ZEROS
		: extended_loss_select_in ? lrx_pkg::LOS_E1_EXT_ZEROS
		: lrx_pkg::LOS_E1_ZEROS;
	assign run_limit = e1_mode ? lrx_pkg::CLR_E1_RUN
		: lrx_pkg::CLR_T1_RUN;
	assign win_len   = e1_mode ? lrx_pkg::CLR_E1_WIN
		: lrx_pkg::CLR_T1_WIN;
	assign ones_need = e1_mode ? lrx_pkg::CLR_E1_ONES
		: lrx_pkg::CLR_T1_ONES;
	// ones restart the run; saturate so long losses do not wrap
	assign next_run = rx_mark ? '0
		: (zero_run == lrx_pkg::ZRUN_MAX) ? zero_run
		: zero_run + 1'b1;
	assign next_ones = ones_cnt + {7'h00, rx_mark};
	assign next_bad  = run_bad | (next_run > run_limit);
	assign win_end   = (win_cnt == win_len - 1'b1);

	// zero counter only runs once the analog detector has fired
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			zero_run <= '0;
		else if (ce_in)
		begin
			if (~aloss & ~receive_loss_flag_out)
				zero_run <= '0;
			else if (rclk_rise)
				zero_run <= next_run;
		end
	end

	// density window, restarted at each end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			win_cnt  <= '0;
			ones_cnt <= '0;
			run_bad  <= 1'b0;
		end
		else if (ce_in & rclk_rise)
		begin
			if (win_end)
			begin
				win_cnt  <= '0;
				ones_cnt <= '0;
				run_bad  <= 1'b0;
			end
			else
			begin
				win_cnt  <= win_cnt + 1'b1;
				ones_cnt <= next_ones;
				run_bad  <= next_bad;
			end
		end
	end

	// flag holds until a whole clean window with restored level
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			receive_loss_flag_out <= 1'b0;
		else if (ce_in)
		begin
			if (~receive_loss_flag_out)
			begin
				if (aloss & (zero_run >= los_thresh))
					receive_loss_flag_out <= 1'b1;
			end
			else if (rclk_rise & win_end & pin_s2[lrx_pkg::P_AREST]
				& (next_ones >= ones_need) & ~next_bad)
				receive_loss_flag_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// sticky status and interrupt; a new event beats the read
	// ------------------------------------------------------------
	logic los_prev;    // flag one cycle ago
	logic los_event;
	logic next_status;

	assign los_event = receive_loss_flag_out ^ los_prev;
	assign next_status = los_event
		| (loss_status_out & ~status_read_in);

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			los_prev        <= 1'b0;
			loss_status_out <= 1'b0;
			int_n_out       <= 1'b1;
		end
		else if (ce_in)
		begin
			los_prev        <= receive_loss_flag_out;
			loss_status_out <= next_status;
			int_n_out <= ~(next_status & loss_int_enable_in);
		end
	end

	// ------------------------------------------------------------
	// jitter attenuator: FIFO plus fill, narrow and wide control
	// ------------------------------------------------------------
	lrx_pkg::lrx_ja_state_e ja_state;
	logic       ja_rx;          // attenuator in receive path
	logic       ja_tx;          // attenuator in transmit path
	logic [6:0] ja_limit;       // active length
	logic       near_edge;      // inside two bit margin
	logic       wr_valid;
	logic       wr_ready;
	logic [1:0] wr_data;
	logic       rd_ready;
	logic       rd_valid;
	logic [1:0] rd_data;
	logic       wr_clk_lvl;     // level of the write side clock

	assign ja_rx = (ja_path_in == lrx_pkg::JA_RX);
	assign ja_tx = (ja_path_in == lrx_pkg::JA_TX);
	// E1 narrow band needs the long FIFO
	assign ja_limit = (ja_depth_long_in
		| (e1_mode & attenuator_bandwidth_select_in))
		? lrx_pkg::JA_LONG : lrx_pkg::JA_SHORT;
	assign near_edge = (ja_level_out <= lrx_pkg::JA_MARGIN)
		| (ja_level_out >= ja_limit - lrx_pkg::JA_MARGIN);
	// write side follows the incoming data clock
	assign wr_valid = ja_rx ? rclk_rise : (ja_tx & tclk_rise);
	assign wr_data  = ja_rx ? rx_sym
		: {pin_s2[lrx_pkg::P_TNEG], pin_s2[lrx_pkg::P_TPOS]};
	assign wr_clk_lvl = ja_rx ? pin_s2[lrx_pkg::P_RCLK]
		: pin_s2[lrx_pkg::P_TCLK];
	// narrow: master clock paces reads; wide: reads track writes plus
	// master ticks, none near empty, so the level walks back out of
	// the margin instead of parking on it
	assign rd_ready = (ja_state == lrx_pkg::JS_NARROW) ? mclk_rise
		: (ja_state != lrx_pkg::JS_WIDE) ? 1'b0
		: (ja_level_out <= lrx_pkg::JA_MARGIN) ? 1'b0
		: (wr_valid | mclk_rise);

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			ja_state <= lrx_pkg::JS_FILL;
		else if (ce_in)
		begin
			case (ja_state)
				lrx_pkg::JS_FILL:
					// hold reads until half full: the nominal delay
					if (ja_level_out >= (ja_limit >> 1))
						ja_state <= lrx_pkg::JS_NARROW;
				lrx_pkg::JS_NARROW:
					if (near_edge)
						ja_state <= lrx_pkg::JS_WIDE;
				lrx_pkg::JS_WIDE:
					if (~near_edge)
						ja_state <= lrx_pkg::JS_NARROW;
				default:
					ja_state <= lrx_pkg::JS_FILL;
			endcase
			if (~(ja_rx | ja_tx))
				ja_state <= lrx_pkg::JS_FILL;
		end
	end

	lrx_fifo #(
		.WIDTH (lrx_pkg::JA_WIDTH),
		.DEPTH (lrx_pkg::JA_DEPTH),
		.AW    (lrx_pkg::JA_AW)
	) u_ja_fifo (
		.clock_in     (clock_in),
		.rst_in       (rst_in),
		.ce_in        (ce_in),
		.clear_in     (~(ja_rx | ja_tx)),
		.limit_in     (ja_limit),
		.wr_valid_in  (wr_valid),
		.wr_ready_out (wr_ready),
		.wr_data_in   (wr_data),
		.rd_ready_in  (rd_ready),
		.rd_valid_out (rd_valid),
		.rd_data_out  (rd_data),
		.level_out    (ja_level_out)
	);

	// overflow only if tracking failed; cleared with the status read
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ja_overflow_out <= 1'b0;
			ja_wide_out     <= 1'b0;
		end
		else if (ce_in)
		begin
			ja_overflow_out <= (wr_valid & ~wr_ready)
				| (ja_overflow_out & ~status_read_in);
			ja_wide_out <= (ja_state == lrx_pkg::JS_WIDE);
		end
	end

	// ------------------------------------------------------------
	// decoder: eight bit delay line with substitution removal
	// ------------------------------------------------------------
	logic [7:0] d_mark;     // pulse present, index 0 newest
	logic [7:0] d_pol;      // pulse is negative
	logic [7:0] d_vio;      // violation to report
	logic       last_pol;   // polarity of the latest pulse
	logic [2:0] zcnt;       // raw zeros, saturating
	logic       dec_step;   // a bit enters the decoder
	logic [1:0] in_sym;
	logic       in_mark;
	logic       in_pol;
	logic       in_bpv;     // same polarity as previous pulse
	logic       hdb3_v;
	logic       hdb3_b;
	logic       b8zs;
	logic       exz;
	logic [7:0] clr;        // earlier pulses to remove
	logic       subst;

	// receive data goes through the attenuator before decoding
	assign dec_step = ja_rx ? rd_valid : rclk_rise;
	assign in_sym  = ja_rx ? rd_data : rx_sym;
	assign in_mark = |in_sym;
	assign in_pol  = in_sym[1];
	assign in_bpv  = in_mark & (in_pol == last_pol);
	assign hdb3_v = e1_mode & ~ami & in_bpv
		& ~d_mark[0] & ~d_mark[1] & ~d_mark[2];
	assign hdb3_b = e1_mode & ~ami & in_bpv & d_mark[2]
		& ~d_mark[1] & ~d_mark[0] & (d_pol[2] == in_pol);
	assign b8zs = ~e1_mode & ~ami & in_mark & ~d_mark[6] & ~d_mark[5]
		& ~d_mark[4] & d_mark[3] & d_mark[2] & ~d_mark[1] & d_mark[0]
		& (d_pol[3] != d_pol[2]) & (d_pol[0] == d_pol[2])
		& (in_pol == d_pol[3]);
	assign exz = e1_mode & ~ami & ~in_mark
		& (zcnt == lrx_pkg::EXZ_RUN);
	assign subst = hdb3_v | hdb3_b | b8zs;
	assign clr = b8zs ? lrx_pkg::B8ZS_MASK
		: hdb3_b ? lrx_pkg::HDB3_MASK : '0;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			d_mark   <= '0;
			d_pol    <= '0;
			d_vio    <= '0;
			last_pol <= 1'b0;
			zcnt     <= '0;
		end
		else if (ce_in & dec_step)
		begin
			d_mark <= {d_mark[6:0] & ~clr[6:0], in_mark & ~subst};
			d_pol  <= {d_pol[6:0], in_pol};
			// AMI reports every violation, coded modes only strays and E1 excessive zeros
			d_vio  <= {d_vio[6:0] & ~clr[6:0],
				~subst & (in_bpv | exz)};
			if (in_mark)
				last_pol <= in_pol;
			if (in_mark)
				zcnt <= '0;
			else if (zcnt != lrx_pkg::EXZ_RUN + 1'b1)
				zcnt <= zcnt + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// output staging and edge-selected update
	// ------------------------------------------------------------
	logic stage_pos;    // bit waiting for the output edge
	logic stage_neg;
	logic oclk_src;     // clock level shown to the framer
	logic out_edge;
	logic ja_clk_lvl;   // smoothed clock level

	assign ja_clk_lvl = (ja_state == lrx_pkg::JS_WIDE) ? wr_clk_lvl
		: pin_s2[lrx_pkg::P_MCLK];
	assign oclk_src = ja_rx ? ja_clk_lvl : pin_s2[lrx_pkg::P_RCLK];
	assign out_edge = edge_fall ? (rx_clock_out & ~oclk_src)
		: (~rx_clock_out & oclk_src);

	// single rail shows data and violation, dual rail raw rails
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			stage_pos <= 1'b0;
			stage_neg <= 1'b0;
		end
		else if (ce_in & dec_step)
		begin
			stage_pos <= single_rail ? d_mark[7] : in_sym[0];
			stage_neg <= single_rail ? d_vio[7] : in_sym[1];
		end
	end

	// one output clock period per bit gives a one period pulse
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			rx_clock_out              <= 1'b0;
			rx_positive_data_out      <= 1'b0;
			rx_negative_violation_out <= 1'b0;
		end
		else if (ce_in)
		begin
			rx_clock_out <= oclk_src;
			if (out_edge)
			begin
				rx_positive_data_out      <= stage_pos;
				rx_negative_violation_out <= stage_neg;
			end
		end
	end

	// transmit side: smoothed stream or plain pass-through
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			tx_clock_out <= 1'b0;
			tx_pos_out   <= 1'b0;
			tx_neg_out   <= 1'b0;
		end
		else if (ce_in)
		begin
			if (ja_tx)
			begin
				tx_clock_out <= ja_clk_lvl;
				if (rd_valid)
				begin
					tx_pos_out <= rd_data[0];
					tx_neg_out <= rd_data[1];
				end
			end
			else
			begin
				tx_clock_out <= pin_s2[lrx_pkg::P_TCLK];
				tx_pos_out   <= pin_s2[lrx_pkg::P_TPOS];
				tx_neg_out   <= pin_s2[lrx_pkg::P_TNEG];
			end
		end
	end

endmodule // lrx_rx_line

// File: lrx_rx_line_asserts.sv
// Purpose: port checks for the line receive block
// Assumes: one clock domain, reset high
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module lrx_rx_line_asserts (
	// controls
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic analog_loss_in,
	input wire logic analog_restore_in,
	input wire logic loss_int_enable_in,
	input wire logic status_read_in,
	input wire logic rx_clock_edge_select_in,
	input wire logic rail_format_select_in,
	input wire logic hw_mode_in,
	input wire logic rx_clock_edge_pin_in,
	// outputs
	input wire logic receive_loss_flag_out,
	input wire logic loss_status_out,
	input wire logic int_n_out,
	input wire logic rx_clock_out,
	input wire logic rx_positive_data_out,
	input wire logic rx_negative_violation_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// interrupt armed; loss flag quiet
	sequence armed; loss_status_out && loss_int_enable_in; endsequence
	sequence quiet; $stable(receive_loss_flag_out); endsequence
	loss_set_a: assert property ($rose(receive_loss_flag_out)
		|-> $past(analog_loss_in, 4)) else $error("flag set");
	loss_clr_a: assert property ($fell(receive_loss_flag_out)
		|-> $past(analog_restore_in, 4)) else $error("flag clear");
	status_set_a: assert property ($changed(receive_loss_flag_out)
		|-> ##[0:1] loss_status_out) else $error("status set");
	int_low_a: assert property (armed ##1 armed |-> !int_n_out)
		else $error("int low");
	read_clr_a: assert property (status_read_in ##0 quiet ##1 quiet
		|-> !loss_status_out) else $error("status read");
	int_high_a: assert property ($fell(loss_status_out) |-> int_n_out)
		else $error("int high");
	vio_pulse_a: assert property ($rose(rx_negative_violation_out)
		&& rail_format_select_in |-> ##[1:16] !rx_negative_violation_out)
		else $error("vio length");
	out_edge_a: assert property ($changed(rx_positive_data_out)
		&& $stable(rail_format_select_in) |-> ((hw_mode_in ?
		rx_clock_edge_pin_in : rx_clock_edge_select_in) ?
		$fell(rx_clock_out) : $rose(rx_clock_out))) else $error("data edge");
endmodule // lrx_rx_line_asserts

bind lrx_rx_line lrx_rx_line_asserts u_lrx_rx_line_asserts (.*);

// File: tb.sv
// Purpose: bench for loss, decode and output paths
// Assumes: rclk 80 ns, runs only while bits are sent
// Notes:   expected tallies come from line patterns
`timescale 1ns/1ps
module tb;
	logic clock_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, rclk_in = 1'h0;
	logic mclk_in = 1'h0, rx_pos_in = 1'h0, rx_neg_in = 1'h0, hw_mode_in = 1'h0;
	logic analog_loss_in = 1'h0, analog_restore_in = 1'h0, tx_pos_in = 1'h0;
	logic rx_clock_edge_pin_in = 1'h1, tx_clock_in = 1'h0, tx_neg_in = 1'h0;
	logic tx_negative_coding_pin_in = 1'h0, coding_select_in = 1'h0;
	logic rx_clock_edge_select_in = 1'h0, rail_format_select_in = 1'h0;
	logic extended_loss_select_in = 1'h0, ja_depth_long_in = 1'h0;
	logic attenuator_bandwidth_select_in = 1'h0, loss_int_enable_in = 1'h1;
	logic status_read_in = 1'h0;
	logic [4:0] equalizer_control_in = 5'h18;
	logic [1:0] ja_path_in = 2'h0;
	logic rx_clock_out, rx_positive_data_out, rx_negative_violation_out;
	logic receive_loss_flag_out, loss_status_out, int_n_out, ja_wide_out;
	logic tx_clock_out, tx_pos_out, tx_neg_out, ja_overflow_out;
	logic [6:0] ja_level_out;
	logic [7:0] ones, vios;
	int err_total = 0, total_checks = 0;
	always #5 clock_in = ~clock_in;
	always #40 mclk_in = ~mclk_in;
	lrx_rx_line u_lrx_rx_line (.*);
	lrx_framer u_lrx_framer (.clock_in, .rst_in, .fall_in(hw_mode_in ?
		rx_clock_edge_pin_in : rx_clock_edge_select_in),
		.rx_clock_in(rx_clock_out),
		.data_in(rx_positive_data_out), .vio_in(rx_negative_violation_out),
		.ones_out(ones), .vios_out(vios));
	task automatic tick(int n);
		repeat (n) @(posedge clock_in);
	endtask
	// one symbol: rails settle, then rclk high
	task automatic sym(logic p, logic n);
		rx_pos_in <= p;
		rx_neg_in <= n;
		tick(4);
		rclk_in <= 1'h1;
		tick(4);
		rclk_in <= 1'h0;
	endtask
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic los(logic [4:0] q, int n);
		equalizer_control_in <= q;
		status_read_in <= 1'h1;
		tick(1);
		status_read_in <= 1'h0;
		tick(2);
		chk("int_n", 1, int_n_out);
		analog_loss_in <= 1'h1;
		analog_restore_in <= 1'h0;
		repeat (n - 1) sym(0, 0);
		chk("early", 0, receive_loss_flag_out);
		repeat (4) sym(0, 0);
		chk("int_n", 0, int_n_out);
		repeat (40) sym(1, 0);
		chk("hold", 1, receive_loss_flag_out);
		analog_loss_in <= 1'h0;
		analog_restore_in <= 1'h1;
		repeat (270) sym(1, 0);
		repeat (12) sym(0, 0);
		chk("clear", 0, receive_loss_flag_out);
	endtask
	task automatic line(string p, logic [7:0] n1, logic [7:0] nv);
		logic [7:0] o0, v0;
		sym(0, 1);
		repeat (40) sym(0, 0);
		o0 = ones;
		v0 = vios;
		foreach (p[i]) sym(p[i] == "+", p[i] == "-");
		repeat (40) sym(0, 0);
		chk("ones", n1, ones - o0);
		chk("vios", nv, vios - v0);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		tick(20);
		rst_in <= 1'h0;
		los(5'h18, 32);
		los(5'h00, 175);
		extended_loss_select_in <= 1'h1;
		los(5'h18, 4096);
		rail_format_select_in <= 1'h1;
		line("+000+-00-++", 3, 2);
		coding_select_in <= 1'h1;
		line("+-++", 4, 1);
		hw_mode_in <= 1'h1;
		tx_negative_coding_pin_in <= 1'h1;
		coding_select_in <= 1'h0;
		equalizer_control_in <= 5'h00;
		line("+--", 3, 1);
		hw_mode_in <= 1'h0;
		line("+000+-0-+", 1, 0);
		rail_format_select_in <= 1'h0;
		line("+-++", 3, 1);
		rail_format_select_in <= 1'h1;
		equalizer_control_in <= 5'h18;
		rx_clock_edge_select_in <= 1'h1;
		ja_path_in <= 2'h1;
		line("+000+-00-++", 3, 2);
		chk("lvl32", 1, (ja_level_out - 7'h0F) <= 7'h02);
		attenuator_bandwidth_select_in <= 1'h1;
		ja_path_in <= 2'h0;
		tick(1);
		ja_path_in <= 2'h1;
		repeat (48) sym(0, 0);
		chk("lvl64", 1, (ja_level_out - 7'h1F) <= 7'h02);
		tick(300);
		chk("wide", 1, ja_wide_out);
		sym(0, 0);
		tick(2);
		chk("narrow", 0, ja_wide_out);
		tx_pos_in <= 1'h1;
		tick(4);
		chk("tx", 1, tx_pos_out);
		end_of_test();
	end
endmodule // tb
